// File: hw/ld_route_pkg.sv
/*
 * constants and carriers for the logical device decode and irq/dma router.
 * assumes one 10 MHz clock and host i/o cycles presented one per clock.
 */
package ld_route_pkg;
    // ************************************************************
    // slots and configuration indices
    // ************************************************************
    localparam int         NSLOT        = 8;
    localparam int         NUART        = 6;
    localparam int         SLOT_FDC     = 0;
    localparam int         SLOT_PP      = 1;
    localparam logic [7:0] SLOT_LDN [NSLOT] = '{8'h00, 8'h03, 8'h04, 8'h05, 8'h0B, 8'h0C, 8'h0D, 8'h0E};
    localparam logic [7:0] LD_RUNTIME   = 8'h0A;
    localparam logic [7:0] IDX_LDN      = 8'h07;
    localparam logic [7:0] IDX_PWR      = 8'h22;
    localparam logic [7:0] IDX_CFG_LO   = 8'h26;
    localparam logic [7:0] IDX_CFG_HI   = 8'h27;
    localparam logic [7:0] IDX_ACT      = 8'h30;
    localparam logic [7:0] IDX_BASE_HI  = 8'h60;
    localparam logic [7:0] IDX_BASE_LO  = 8'h61;
    localparam logic [7:0] IDX_KEY_HI   = 8'h62;
    localparam logic [7:0] IDX_KEY_LO   = 8'h63;
    localparam logic [7:0] IDX_IRQ      = 8'h70;
    localparam logic [7:0] IDX_DMA      = 8'h74;
    localparam logic [7:0] IDX_DMA2     = 8'h75;
    // ************************************************************
    // address ranges and reset values
    // ************************************************************
    localparam logic [11:0] CFG_BASE_LO  = 12'h02E;
    localparam logic [11:0] CFG_BASE_HI  = 12'h04E;
    localparam logic [11:0] DEV_BASE_MIN = 12'h100;
    localparam logic [11:0] DEV_BASE_MAX = 12'hFF8;
    localparam logic [11:0] PP_BASE_MAX  = 12'hFFC;
    localparam logic [11:0] KEY_BASE_MAX = 12'hFDF;
    localparam logic [11:0] MASK_8B      = 12'hFF8;
    localparam logic [11:0] MASK_4B      = 12'hFFC;
    localparam logic [7:0]  IRQ_RST_FDC  = 8'h06;
    localparam logic [7:0]  IRQ_RST      = 8'h00;
    localparam logic [7:0]  DMA_RST_FDC  = 8'h02;
    localparam logic [7:0]  DMA_RST      = 8'h04;
    localparam logic [3:0]  IRQ_NONE     = 4'h0;
    localparam logic [3:0]  IRQ_CODE_15  = 4'hE;
    localparam logic [3:0]  IRQ_LINE_15  = 4'hF;
    localparam logic [2:0]  DMA_CH_MIN   = 3'h1;
    localparam logic [2:0]  DMA_CH_MAX   = 3'h3;
    localparam logic [2:0]  PP_MODE_ECP  = 3'h3;
    localparam logic [2:0]  PP_MODE_EPP  = 3'h4;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic [15:0] addr;
        logic        wr;
        logic        rd;
        logic [7:0]  wdata;
    } io_req_t;

    typedef struct packed {
        logic       printer_irq_gate;
        logic       ecp_service_irq_mask;
        logic       ecp_dma_gate;
        logic [2:0] mode;
    } printer_ctl_t;
endpackage

// File: hw/ld_route.sv
/*
 * logical device address decode, configuration index/data port and
 * routing of device interrupts and dma requests onto system lines.
 * assumes host i/o cycles are single-clock strobes synchronous to clock_i
 * and that device-local enable bits arrive as levels from each block.
 */
`timescale 1ns/10ps

// Behaviour
// - decode 32-byte key block at programmed base
// - extra uarts decode eight bytes at base
// - config port relocatable, index then data
// - compare A11..A0, require A15..A12 zero
// - config port starts at strap-selected address
// - irq code maps to line, E is 15
// - edge irqs, printer ecp/epp level, smi low
// - irq select resets 06 floppy, else 00
// - irq needs nonzero select, floppy gate bit
// - printer irq needs gate, ecp unmasked service
// - uart irq needs enable bit and aux two
// - unselected irq lines stay undriven
// - dma codes 1-3 channels, others none
// - dma needs valid code and local gate
// - dma select resets 02 floppy, else 04
// - unselected dma channels stay undriven
// - local disable, inactive, bad base: off
// - activate and power bits are one bit
// - invalid base address ignores host access
// - index 75 ignores writes, reads zero
module ld_route import ld_route_pkg::*; (
    input  wire logic                  clock_i,               // 10 MHz clock
    input  wire logic                  nrst_i,                // sync reset, low
    input  wire logic                  cfg_port_strap_i,      // config port strap
    input  wire io_req_t               io_req_i,              // host i/o cycle
    input  wire logic [NSLOT-1:0]      dev_irq_i,             // per slot irq request
    input  wire logic [NSLOT-1:0]      dev_dma_req_i,         // per slot dma request
    input  wire logic                  floppy_dma_irq_gate_i, // floppy irq/dma gate
    input  wire printer_ctl_t          printer_i,             // printer port controls
    input  wire logic [NUART-1:0][3:0] uart_irq_enable_reg_i, // uart irq enables
    input  wire logic [NUART-1:0]      uart_aux_output_two_i, // uart aux output two
    input  wire logic                  smi_req_i,             // system mgmt request
    output logic [7:0]                 io_rdata_o,            // config read data
    output logic                       io_rvalid_o,           // config read answer
    output logic [NSLOT-1:0]           dev_hit_o,             // device window hit
    output logic [2:0]                 dev_offset_o,          // offset in window
    output logic                       key_hit_o,             // key block hit
    output logic [4:0]                 key_offset_o,          // key byte number
    output logic [15:0]                irq_o,                 // irq line levels
    output logic [15:0]                irq_oe_n_o,            // irq drive, low = on
    output logic [3:0]                 dma_req_o,             // dma channel request
    output logic [3:0]                 dma_oe_n_o,            // dma drive, low = on
    output logic                       sys_mgmt_irq_n_o       // smi, low active
);
    // ************************************************************
    // state
    // ************************************************************
    logic [7:0]  index_q;
    logic [7:0]  ldn_q;
    logic [11:0] cfg_base_q;
    logic [11:0] key_base_q;
    logic [NSLOT-1:0]       act_q;
    logic [NSLOT-1:0][11:0] base_q;
    logic [NSLOT-1:0][7:0]  irq_sel_q;
    logic [NSLOT-1:0][7:0]  dma_sel_q;
    logic [NSLOT-1:0]       irq_prev_q;

    logic [11:0]      a12;
    logic             upper_ok;
    logic             idx_hit;
    logic             dat_hit;
    logic             dat_wr;
    logic             key_ok;
    logic             key_hit;
    logic [NSLOT-1:0] slot_sel;
    logic [NSLOT-1:0] usable;
    logic [NSLOT-1:0] hit;
    logic [NSLOT-1:0] irq_ok;
    logic [NSLOT-1:0] irq_act;
    logic [NSLOT-1:0] dma_ok;
    logic [3:0]       irq_line [NSLOT];
    logic [15:0]      line_en;
    logic [15:0]      line_val;
    logic [3:0]       ch_en;
    logic [3:0]       ch_val;
    logic [7:0]       rd_d;
    logic             ecp_mode;

    // ************************************************************
    // host address decode
    // ************************************************************
    // upper nibble must be clear, only twelve bits are compared
    assign a12      = io_req_i.addr[11:0];
    assign upper_ok = (io_req_i.addr[15:12] == 4'h0);
    // index at even base, data at base plus one
    assign idx_hit  = upper_ok && (a12 == {cfg_base_q[11:1], 1'b0});
    assign dat_hit  = upper_ok && (a12 == {cfg_base_q[11:1], 1'b1});
    assign dat_wr   = io_req_i.wr && dat_hit;
    assign ecp_mode = (printer_i.mode == PP_MODE_ECP);

    // key block needs 32-byte alignment inside its range
    assign key_ok  = (key_base_q[4:0] == 5'h00) && (key_base_q <= KEY_BASE_MAX);
    assign key_hit = upper_ok && key_ok && (a12[11:5] == key_base_q[11:5]);

    // ************************************************************
    // per slot decode, gating and routing
    // ************************************************************
    for (genvar s = 0; s < NSLOT; s++) begin : g_slot
        localparam int U = (s >= 2) ? s - 2 : 0;
        logic        base_ok;
        logic [11:0] mask;
        logic        gate_irq;
        logic        gate_dma;
        logic        level_mode;
        logic [3:0]  code;
        logic [2:0]  dcode;

        assign slot_sel[s] = (ldn_q == SLOT_LDN[s]);
        assign code        = irq_sel_q[s][3:0];
        assign dcode       = dma_sel_q[s][2:0];

        // printer may sit on 4-byte boundaries, the rest on 8
        if (s == SLOT_PP) begin : g_pp
            assign base_ok    = (base_q[s][1:0] == 2'h0) && (base_q[s] >= DEV_BASE_MIN)
                                && (base_q[s] <= PP_BASE_MAX);
            assign mask       = base_q[s][2] ? MASK_4B : MASK_8B;
            assign gate_irq   = printer_i.printer_irq_gate
                                && !(ecp_mode && printer_i.ecp_service_irq_mask);
            assign gate_dma   = ecp_mode && printer_i.ecp_dma_gate;
            assign level_mode = ecp_mode || (printer_i.mode == PP_MODE_EPP);
        end else begin : g_std
            assign base_ok    = (base_q[s][2:0] == 3'h0) && (base_q[s] >= DEV_BASE_MIN)
                                && (base_q[s] <= DEV_BASE_MAX);
            assign mask       = MASK_8B;
            assign level_mode = 1'b0;
            if (s == SLOT_FDC) begin : g_fdc
                assign gate_irq = floppy_dma_irq_gate_i;
                assign gate_dma = floppy_dma_irq_gate_i;
            end else begin : g_uart
                // no dma gate of its own inside a uart slot
                assign gate_irq = (|uart_irq_enable_reg_i[U]) && uart_aux_output_two_i[U];
                assign gate_dma = 1'b1;
            end
        end

        // inactive or badly placed devices neither decode nor route
        assign usable[s]   = act_q[s] && base_ok;
        assign hit[s]      = upper_ok && usable[s] && (((a12 ^ base_q[s]) & mask) == 12'h000);
        assign irq_ok[s]   = usable[s] && gate_irq && (code != IRQ_NONE);
        assign irq_line[s] = (code == IRQ_CODE_15) ? IRQ_LINE_15 : code;
        // edge lines pulse once per rising request, level lines follow it
        assign irq_act[s]  = level_mode ? dev_irq_i[s] : (dev_irq_i[s] && !irq_prev_q[s]);
        // code 0 and codes 4-7 fall outside the channel range
        assign dma_ok[s]   = usable[s] && gate_dma
                             && (dcode >= DMA_CH_MIN) && (dcode <= DMA_CH_MAX);

        // per slot configuration registers
        always_ff @(posedge clock_i) begin
            if (!nrst_i) begin
                act_q[s]     <= 1'b0;
                base_q[s]    <= 12'h000;
                irq_sel_q[s] <= (s == SLOT_FDC) ? IRQ_RST_FDC : IRQ_RST;
                dma_sel_q[s] <= (s == SLOT_FDC) ? DMA_RST_FDC : DMA_RST;
            end else if (dat_wr) begin
                // one flop backs both activate and power bit
                if (index_q == IDX_PWR) begin
                    act_q[s] <= io_req_i.wdata[s];
                end else if (slot_sel[s]) begin
                    unique case (index_q)
                        IDX_ACT:     act_q[s]        <= io_req_i.wdata[0];
                        IDX_BASE_HI: base_q[s][11:8] <= io_req_i.wdata[3:0];
                        IDX_BASE_LO: base_q[s][7:0]  <= io_req_i.wdata;
                        IDX_IRQ:     irq_sel_q[s]    <= io_req_i.wdata;
                        IDX_DMA:     dma_sel_q[s]    <= io_req_i.wdata;
                        default:     ;
                    endcase
                end
            end
        end

        // request history for edge detection
        always_ff @(posedge clock_i) begin
            if (!nrst_i) begin
                irq_prev_q[s] <= 1'b0;
            end else begin
                irq_prev_q[s] <= dev_irq_i[s];
            end
        end
    end

    // ************************************************************
    // line and channel merge
    // ************************************************************
    // several slots may share a line, requests are or-ed
    always_comb begin
        line_en  = 16'h0000;
        line_val = 16'h0000;
        ch_en    = 4'h0;
        ch_val   = 4'h0;
        for (int s = 0; s < NSLOT; s++) begin
            if (irq_ok[s]) begin
                line_en[irq_line[s]]  = 1'b1;
                line_val[irq_line[s]] = line_val[irq_line[s]] | irq_act[s];
            end
            if (dma_ok[s]) begin
                ch_en[dma_sel_q[s][1:0]]  = 1'b1;
                ch_val[dma_sel_q[s][1:0]] = ch_val[dma_sel_q[s][1:0]] | dev_dma_req_i[s];
            end
        end
    end

    // routed outputs, undriven lines read low with enable high
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            irq_o            <= 16'h0000;
            irq_oe_n_o       <= 16'hFFFF;
            dma_req_o        <= 4'h0;
            dma_oe_n_o       <= 4'hF;
            sys_mgmt_irq_n_o <= 1'b1;
        end else begin
            irq_o            <= line_val;
            irq_oe_n_o       <= ~line_en;
            dma_req_o        <= ch_val;
            dma_oe_n_o       <= ~ch_en;
            // shares irq2 wiring; software keeps the two apart
            sys_mgmt_irq_n_o <= ~smi_req_i;
        end
    end

    // ************************************************************
    // configuration port registers
    // ************************************************************
    // index and logical device number
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            index_q <= 8'h00;
            ldn_q   <= 8'h00;
        end else if (io_req_i.wr && idx_hit) begin
            index_q <= io_req_i.wdata;
        end else if (dat_wr && (index_q == IDX_LDN)) begin
            ldn_q <= io_req_i.wdata;
        end
    end

    // strap is sampled while reset is held, a sync reset permits it
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            cfg_base_q <= cfg_port_strap_i ? CFG_BASE_HI : CFG_BASE_LO;
        end else if (dat_wr && (index_q == IDX_CFG_LO)) begin
            cfg_base_q[7:0] <= {io_req_i.wdata[7:1], 1'b0};
        end else if (dat_wr && (index_q == IDX_CFG_HI)) begin
            cfg_base_q[11:8] <= io_req_i.wdata[3:0];
        end
    end

    // key block base lives in the runtime device
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            key_base_q <= 12'h000;
        end else if (dat_wr && (ldn_q == LD_RUNTIME) && (index_q == IDX_KEY_HI)) begin
            key_base_q[11:8] <= io_req_i.wdata[3:0];
        end else if (dat_wr && (ldn_q == LD_RUNTIME) && (index_q == IDX_KEY_LO)) begin
            key_base_q[7:0] <= io_req_i.wdata;
        end
    end

    // read mux; unknown indices and index 75 return zero
    always_comb begin
        rd_d = 8'h00;
        if (idx_hit) begin
            rd_d = index_q;
        end else if (index_q == IDX_LDN) begin
            rd_d = ldn_q;
        end else if (index_q == IDX_PWR) begin
            rd_d = act_q;
        end else if (index_q == IDX_CFG_LO) begin
            rd_d = cfg_base_q[7:0];
        end else if (index_q == IDX_CFG_HI) begin
            rd_d = {4'h0, cfg_base_q[11:8]};
        end else if (ldn_q == LD_RUNTIME) begin
            if (index_q == IDX_KEY_HI) begin
                rd_d = {4'h0, key_base_q[11:8]};
            end else if (index_q == IDX_KEY_LO) begin
                rd_d = key_base_q[7:0];
            end
        end else begin
            for (int s = 0; s < NSLOT; s++) begin
                if (slot_sel[s]) begin
                    unique case (index_q)
                        IDX_ACT:     rd_d = {7'h00, act_q[s]};
                        IDX_BASE_HI: rd_d = {4'h0, base_q[s][11:8]};
                        IDX_BASE_LO: rd_d = base_q[s][7:0];
                        IDX_IRQ:     rd_d = irq_sel_q[s];
                        IDX_DMA:     rd_d = dma_sel_q[s];
                        default:     rd_d = 8'h00;
                    endcase
                end
            end
        end
    end

    // read answer and decode strobes, one cycle after the cycle
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            io_rdata_o   <= 8'h00;
            io_rvalid_o  <= 1'b0;
            dev_hit_o    <= '0;
            dev_offset_o <= 3'h0;
            key_hit_o    <= 1'b0;
            key_offset_o <= 5'h00;
        end else begin
            io_rvalid_o  <= io_req_i.rd && (idx_hit || dat_hit);
            io_rdata_o   <= (io_req_i.rd && (idx_hit || dat_hit)) ? rd_d : 8'h00;
            dev_hit_o    <= hit & {NSLOT{io_req_i.rd || io_req_i.wr}};
            dev_offset_o <= a12[2:0];
            key_hit_o    <= key_hit && (io_req_i.rd || io_req_i.wr);
            key_offset_o <= a12[4:0];
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    for (genvar n = 0; n < 16; n++) begin : g_chk
        chk_irq_idle_line: assert property (@(posedge clock_i) disable iff (!nrst_i)
            !line_en[n] |=> irq_oe_n_o[n] && !irq_o[n]) else $error("unselected irq line driven");
    end
    // every channel, so a stuck enable on 1..3 is caught too
    for (genvar n = 0; n < 4; n++) begin : g_dchk
        chk_dma_idle_ch: assert property (@(posedge clock_i) disable iff (!nrst_i)
            !ch_en[n] |=> dma_oe_n_o[n] && !dma_req_o[n]) else $error("unselected dma channel driven");
    end
    chk_key_upper: assert property (@(posedge clock_i) disable iff (!nrst_i)
        key_hit_o |-> $past(io_req_i.addr[15:12]) == 4'h0) else $error("key hit with upper bits set");
    chk_strap_base: assert property (@(posedge clock_i)
        !nrst_i |=> cfg_base_q == ($past(cfg_port_strap_i) ? CFG_BASE_HI : CFG_BASE_LO))
        else $error("config base wrong after reset");
    chk_irq_reset: assert property (@(posedge clock_i)
        !nrst_i |=> irq_sel_q[SLOT_FDC] == IRQ_RST_FDC && irq_sel_q[SLOT_PP] == IRQ_RST)
        else $error("irq select reset value wrong");
    chk_dma_reset: assert property (@(posedge clock_i)
        !nrst_i |=> dma_sel_q[SLOT_FDC] == DMA_RST_FDC && dma_sel_q[3] == DMA_RST)
        else $error("dma select reset value wrong");
    chk_fdc_gate: assert property (@(posedge clock_i) disable iff (!nrst_i)
        !floppy_dma_irq_gate_i |-> !irq_ok[SLOT_FDC] && !dma_ok[SLOT_FDC]) else $error("floppy gate ignored");
    chk_uart_gate: assert property (@(posedge clock_i) disable iff (!nrst_i)
        !uart_aux_output_two_i[0] |-> !irq_ok[2]) else $error("uart aux two gate ignored");
    chk_index_75: assert property (@(posedge clock_i) disable iff (!nrst_i)
        io_req_i.rd && dat_hit && index_q == IDX_DMA2 |=> io_rvalid_o && io_rdata_o == 8'h00)
        else $error("index 75 not read as zero");
    chk_smi_low: assert property (@(posedge clock_i) disable iff (!nrst_i)
        smi_req_i ##1 smi_req_i |-> !sys_mgmt_irq_n_o) else $error("smi not driven low");
endmodule

// File: test/irq_dma_sink.sv
/* far-side model: system irq and dma lines with pull-downs.
   assumes the router's oe_n outputs are low while it drives a line. */
`timescale 1ns/10ps
module irq_dma_sink (
    input  wire logic [15:0] irq_i,      // router irq values
    input  wire logic [15:0] irq_oe_n_i, // router irq drive, low = on
    input  wire logic [3:0]  dma_i,      // router dma requests
    input  wire logic [3:0]  dma_oe_n_i, // router dma drive, low = on
    output logic      [15:0] irq_line_o, // resolved irq wires
    output logic      [3:0]  dma_line_o  // resolved dma wires
);
    // released wires fall to the pull-down level, never keep old values
    assign irq_line_o = irq_i & ~irq_oe_n_i;
    assign dma_line_o = dma_i & ~dma_oe_n_i;
endmodule

// File: test/ld_route_tb_top.sv
/* self-checking bench for the logical device router.
   assumes strap low at first; a mid-run reset raises it and moves the port. */
`timescale 1ns/10ps
module ld_route_tb_top import ld_route_pkg::*;;
    logic clock_i = 0, nrst_i = 0, cfg_port_strap_i = 0, smi_req_i = 0, floppy_dma_irq_gate_i = 0;
    io_req_t io_req_i = '0;
    logic [NSLOT-1:0] dev_irq_i = '0, dev_dma_req_i = '0, dev_hit_o;
    printer_ctl_t printer_i = '0;
    logic [NUART-1:0][3:0] uart_irq_enable_reg_i = '0;
    logic [NUART-1:0] uart_aux_output_two_i = '0;
    logic [7:0] io_rdata_o, lfsr_q = 8'h13;
    logic io_rvalid_o, key_hit_o, sys_mgmt_irq_n_o;
    logic [2:0] dev_offset_o;
    logic [4:0] key_offset_o;
    logic [15:0] irq_o, irq_oe_n_o, irq_line, exp_m, port_q = 16'h002E;
    logic [3:0] dma_req_o, dma_oe_n_o, dma_line, c;
    logic [7:0] exp_q[$];
    int bad_count = 0, n_checks = 0, cycles = 0;
    ld_route dut (
        .clock_i(clock_i), .nrst_i(nrst_i), .cfg_port_strap_i(cfg_port_strap_i), .io_req_i(io_req_i),
        .dev_irq_i(dev_irq_i), .dev_dma_req_i(dev_dma_req_i), .floppy_dma_irq_gate_i(floppy_dma_irq_gate_i),
        .printer_i(printer_i), .uart_irq_enable_reg_i(uart_irq_enable_reg_i),
        .uart_aux_output_two_i(uart_aux_output_two_i), .smi_req_i(smi_req_i), .io_rdata_o(io_rdata_o),
        .io_rvalid_o(io_rvalid_o), .dev_hit_o(dev_hit_o), .dev_offset_o(dev_offset_o), .key_hit_o(key_hit_o),
        .key_offset_o(key_offset_o), .irq_o(irq_o), .irq_oe_n_o(irq_oe_n_o), .dma_req_o(dma_req_o),
        .dma_oe_n_o(dma_oe_n_o), .sys_mgmt_irq_n_o(sys_mgmt_irq_n_o));
    irq_dma_sink sink (.irq_i(irq_o), .irq_oe_n_i(irq_oe_n_o), .dma_i(dma_req_o), .dma_oe_n_i(dma_oe_n_o),
        .irq_line_o(irq_line), .dma_line_o(dma_line));
    // ************************************************************
    // clock, timeout and shared tasks
    // ************************************************************
    initial forever #50 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 4000) begin
            bad_count++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        if (bad_count == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // pseudo-random source for stimulus fields
    function automatic logic [7:0] lfsr_next(logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    // one-cycle host strobe, cleared at the following edge
    task automatic io(logic [15:0] a, logic w, logic r, logic [7:0] d);
        @(posedge clock_i) io_req_i <= io_req_t'{a, w, r, d};
        @(posedge clock_i) io_req_i <= '0;
    endtask
    task automatic wr(logic [7:0] idx, logic [7:0] d);
        io(port_q, 1'b1, 1'b0, idx);
        io(port_q + 16'h0001, 1'b1, 1'b0, d);
    endtask
    task automatic rd(logic [7:0] idx, logic [7:0] e);
        io(port_q, 1'b1, 1'b0, idx);
        exp_q.push_back(e);
        io(port_q + 16'h0001, 1'b0, 1'b1, 8'h00);
    endtask
    // results of config reads are matched against the oldest note
    always @(negedge clock_i) begin
        if (io_rvalid_o === 1'b1) chk("cfg read", {8'h00, exp_q.pop_front()}, {8'h00, io_rdata_o});
    end
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        repeat (20) @(posedge clock_i);
        nrst_i <= 1'b1;
        rd(IDX_IRQ, 8'h06);
        rd(IDX_DMA, 8'h02);
        wr(IDX_LDN, 8'h04);
        rd(IDX_DMA, 8'h04);
        wr(IDX_BASE_HI, 8'h03);
        wr(IDX_BASE_LO, 8'hF8);
        wr(IDX_ACT, 8'h01);
        rd(IDX_IRQ, 8'h00);
        wr(IDX_DMA2, 8'h55);
        rd(IDX_DMA2, 8'h00);
        io(16'h03FD, 1'b0, 1'b1, 8'h00);
        @(negedge clock_i) chk("hit", 16'h0025, {5'h0, dev_hit_o, dev_offset_o});
        io(16'h13FD, 1'b0, 1'b1, 8'h00);
        @(negedge clock_i) chk("high addr hit", 16'h0000, {8'h0, dev_hit_o});
        // key block base is zero after reset, so byte 5 sits at 0x005
        io(16'h0005, 1'b0, 1'b1, 8'h00);
        @(negedge clock_i) chk("key hit", 16'h0025, {10'h0, key_hit_o, key_offset_o});
        io(16'h1005, 1'b0, 1'b1, 8'h00);
        @(negedge clock_i) chk("key high addr", 16'h0005, {10'h0, key_hit_o, key_offset_o});
        lfsr_q = lfsr_next(lfsr_q);
        @(posedge clock_i) begin
            uart_irq_enable_reg_i[0] <= 4'h1;
            uart_aux_output_two_i[0] <= 1'b1;
        end
        // random line in 1..D, then code E which lands on line 15
        for (int i = 0; i < 2; i++) begin
            c = (i == 0) ? 4'(lfsr_q % 13 + 1) : IRQ_CODE_15;
            exp_m = 16'h0001 << ((c == IRQ_CODE_15) ? 4'hF : c);
            wr(IDX_IRQ, {4'h0, c});
            @(posedge clock_i) dev_irq_i[2] <= 1'b1;
            @(posedge clock_i);
            @(negedge clock_i) chk("irq edge", exp_m, irq_line);
            @(negedge clock_i) chk("irq after edge", ~exp_m, irq_oe_n_o | irq_o);
            @(posedge clock_i) dev_irq_i[2] <= 1'b0;
        end
        // aux output two off must release every line
        @(posedge clock_i) uart_aux_output_two_i[0] <= 1'b0;
        repeat (2) @(posedge clock_i);
        @(negedge clock_i) chk("irq released", 16'hFFFF, irq_oe_n_o);
        for (int k = 0; k < 8; k++) begin
            wr(IDX_DMA, 8'(k));
            @(posedge clock_i) dev_dma_req_i[2] <= 1'b1;
            @(posedge clock_i);
            exp_m = (k >= 1 && k <= 3) ? (16'h0001 << k) : 16'h0000;
            @(negedge clock_i) chk("dma", exp_m, {12'h0, dma_line});
            chk("dma drive", 16'h000F ^ exp_m, {12'h0, dma_oe_n_o});
            @(posedge clock_i) dev_dma_req_i[2] <= 1'b0;
        end
        // smi only while no device sits on line 2
        @(posedge clock_i) smi_req_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        @(negedge clock_i) chk("smi active", 16'h0000, {15'h0, sys_mgmt_irq_n_o});
        @(posedge clock_i) smi_req_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        @(negedge clock_i) chk("smi idle", 16'h0001, {15'h0, sys_mgmt_irq_n_o});
        // mid-run reset with the strap high moves the port to its other address
        @(posedge clock_i) begin
            nrst_i           <= 1'b0;
            cfg_port_strap_i <= 1'b1;
        end
        repeat (2) @(posedge clock_i);
        nrst_i <= 1'b1;
        port_q = 16'h004E;
        rd(IDX_CFG_LO, 8'h4E);
        rd(IDX_IRQ, 8'h06);
        repeat (3) @(posedge clock_i);
        report_and_stop();
    end
endmodule
